// ---- src/vrc_pkg.sv ----
package vrc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OSC_HZ = 2_000_000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned DEB_MS = 32;
  localparam int unsigned DEB_CYC = (CLK_HZ / 1000) * DEB_MS;

  // Sample dividers by {rate_sel_hi, rate_sel_lo}
  localparam logic [9:0] RATE_DIV_LL = 10'h200;
  localparam logic [9:0] RATE_DIV_LH = 10'h120;
  localparam logic [9:0] RATE_DIV_HL = 10'h100;
  localparam logic [9:0] RATE_DIV_HH = 10'h0E0;

  // ----------------------------------------------------------------------
  // Memory geometry, in 4-bit sample addresses
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int MEM_SHIFT = 18;
  localparam logic [20:0] INDEX_NIBBLES = 21'h000800;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_LIMIT = 8'h0C;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_MCU_BIT = 2;
  localparam int CTRL_REC_BIT = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Nibble commands
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_PLAY = 4'h2;
  localparam logic [3:0] CMD_REC = 4'h3;
  localparam logic [3:0] CMD_START = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h5;
  localparam logic [3:0] CMD_MEMORY_READ_CMD = 4'hC;
  localparam logic [3:0] CMD_MEMORY_WRITE_CMD = 4'hD;
  localparam logic [3:0] CMD_EXTERNAL_PLAYBACK_CMD = 4'hE;
  localparam logic [3:0] CMD_EXTERNAL_RECORD_CMD = 4'hF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PD,
    ST_IDLE,
    ST_REC,
    ST_PLAY,
    ST_XFER
  } vrc_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } vrc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vrc_axi_rsp_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] mem;
    logic [1:0] phrase;
    logic [2:0] ch;
  } vrc_sel_t;

  // ----------------------------------------------------------------------
  // Channel geometry
  // ----------------------------------------------------------------------
  // Share of one channel: total memory over the phrase count
  function automatic logic [20:0] share_calc(input logic [1:0] mem, input logic [1:0] ph);
    logic [20:0] tot;
    tot = (21'(mem) + 21'h000001) << MEM_SHIFT;
    if (mem == 2'h2) begin
      case (ph)
        2'h0: share_calc = tot;
        2'h1: share_calc = tot >> 1;
        2'h2: share_calc = 21'h000001 << MEM_SHIFT;
        default: share_calc = 21'h000001 << (MEM_SHIFT - 1);
      endcase
    end else begin
      share_calc = tot >> ph;
    end
  endfunction

  // Channel pins folded onto the channels that exist
  function automatic logic [2:0] eff_channel(input logic [1:0] mem, input logic [1:0] ph,
                                             input logic [2:0] ch);
    eff_channel = ch;
    if (mem == 2'h2) begin
      case (ph)
        2'h0: eff_channel = 3'h0;
        2'h1: eff_channel = {2'h0, ch[0]};
        2'h2: eff_channel = (ch[1:0] == 2'h3) ? 3'h2 : {1'b0, ch[1:0]};
        default: eff_channel = (ch >= 3'h6) ? ch - 3'h2 : ch;
      endcase
    end else begin
      eff_channel = ch & ((3'h1 << ph) - 3'h1);
    end
  endfunction

endpackage

// ---- src/vrc_debounce.sv ----
module vrc_debounce #(
  parameter int unsigned CYCLES = vrc_pkg::DEB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw and filtered level
  input wire logic raw,
  output logic level
);

  typedef struct packed {
    logic level;
    logic [31:0] cnt;
  } vrc_deb_t;

  vrc_deb_t s_r;
  vrc_deb_t s_nxt;

  // Accept a new level only after it held for the full window
  always_comb begin
    s_nxt = s_r;
    if (raw == s_r.level) begin
      s_nxt.cnt = 32'h0;
    end else if (s_r.cnt >= CYCLES - 1) begin
      s_nxt.level = raw;
      s_nxt.cnt = 32'h0;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;

endmodule // vrc_debounce

// ---- src/vrc_rate_div.sv ----
module vrc_rate_div #(
  parameter int unsigned OSC_DIV = vrc_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator running and rate choice
  input wire logic run,
  input wire logic [1:0] rate,
  // One-cycle pulse per sample
  output logic sample_tick
);

  typedef struct packed {
    logic [7:0] osc_cnt;
    logic [9:0] smp_cnt;
    logic tick;
  } vrc_div_t;

  vrc_div_t s_r;
  vrc_div_t s_nxt;
  logic [9:0] div;

  // Divider from the rate pins
  always_comb begin
    case (rate)
      2'h0: div = vrc_pkg::RATE_DIV_LL;
      2'h1: div = vrc_pkg::RATE_DIV_LH;
      2'h2: div = vrc_pkg::RATE_DIV_HL;
      default: div = vrc_pkg::RATE_DIV_HH;
    endcase
  end

  // Oscillator enable, then sample enable; stopped oscillator clears both counters
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.osc_cnt = 8'h0;
      s_nxt.smp_cnt = 10'h0;
    end else if (s_r.osc_cnt >= 8'(OSC_DIV - 1)) begin
      s_nxt.osc_cnt = 8'h0;
      if (s_r.smp_cnt >= div - 10'h1) begin
        s_nxt.smp_cnt = 10'h0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.smp_cnt = s_r.smp_cnt + 10'h1;
      end
    end else begin
      s_nxt.osc_cnt = s_r.osc_cnt + 8'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sample_tick = s_r.tick;

endmodule // vrc_rate_div

// ---- src/vrc_top.sv ----
// Overview of operation
// [RULE1] Chip-enable-inhibit high: strobes ignored, data bus released.
// [RULE2] Power-down input high puts the device into power-down; code heeds it only when idle in microcontroller mode.
// [RULE3] Write strobe takes a nibble; read strobe drives status or data.
// [RULE4] Transfer clock runs during the four transfer commands.
// [RULE5] Button unused in microcontroller mode; outside holds it low.
// [RULE6] Each sample uses one four-bit memory location.
// [RULE7] Stand-alone and idle: power down, oscillator stopped.
// [RULE8] Rate pins pick oscillator division 512, 288, 256 or 224.
// [RULE9] Oscillator runs between 1.5 and 4 MHz.
// [RULE10] Playback uses the rate selected now, not the recorded one.
// [RULE11] Memory-count pins declare one to four 1-Mbit memories.
// [RULE12] Phrase pins give 1, 2, 4, 8 phrases; 1, 2, 3, 6 with three memories.
// [RULE13] Each channel gets total memory divided by phrase count.
// [RULE14] Channel pins choose which share is used.
// [RULE15] First 8 kbit reserved as index area, shortening channel zero.
// [RULE16] Recording stops by itself when the channel memory is full.
// [RULE17] Activity monitor low while recording or playing.
// [RULE18] Button debounced over 32 ms before acting.
// [RULE19] Recording starts at the channel's first address.
// [RULE20] Select pins sampled at start and held until the end.
module vrc_top #(
  parameter int unsigned DEB_CYC = vrc_pkg::DEB_CYC,
  parameter int unsigned OSC_DIV = vrc_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire vrc_pkg::vrc_axi_req_t axi_req,
  output vrc_pkg::vrc_axi_rsp_t axi_rsp,
  // Microcontroller pins
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic chip_enable_inhibit,
  input wire logic power_down_in,
  input wire logic [3:0] bus_in,
  output logic [3:0] bus_out,
  output logic bus_oe_n,
  output logic transfer_sync_clock,
  // Stand-alone pins
  input wire logic start_stop_button,
  input wire logic rec_play_sel,
  input wire logic rate_sel_lo,
  input wire logic rate_sel_hi,
  input wire logic mem_count_sel_lo,
  input wire logic mem_count_sel_hi,
  input wire logic phrase_count_sel_lo,
  input wire logic phrase_count_sel_hi,
  input wire logic channel_sel_0,
  input wire logic channel_sel_1,
  input wire logic channel_sel_2,
  // Voice memory side
  input wire logic [3:0] mem_nibble_in,
  output logic [3:0] mem_nibble_out,
  output logic [20:0] mem_addr,
  output logic mem_write_en,
  // Activity and oscillator
  output logic activity_monitor_n,
  output logic osc_run
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    vrc_pkg::vrc_state_t st;
    vrc_pkg::vrc_sel_t sel;
    logic mcu_mode;
    logic sw_rec;
    logic mode_rec;
    logic xfer_rec;
    logic [20:0] addr;
    logic [20:0] limit;
    logic [3:0] data_wr;
    logic mem_we;
    logic xclk;
    logic wr_prev;
    logic btn_prev;
    logic [3:0] bus_out;
    logic bus_oe_n;
    logic mon_n;
    logic osc_run;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    vrc_pkg::vrc_axi_rsp_t rsp;
  } vrc_top_t;

  vrc_top_t s_r;
  vrc_top_t s_nxt;
  logic btn_level;
  logic sample_tick;
  vrc_pkg::vrc_sel_t pins;
  logic [20:0] share;
  logic [2:0] ch_eff;
  logic [20:0] ch_base;
  logic [20:0] ch_first;
  logic active;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Button filter; its level is ignored in microcontroller mode
  vrc_debounce #(
    .CYCLES(DEB_CYC)
  ) u_deb (
    .clk(clk),
    .rst(rst),
    .raw(start_stop_button),
    .level(btn_level)
  );

  // Sample clock from the held rate
  vrc_rate_div #(
    .OSC_DIV(OSC_DIV)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .run(s_r.osc_run),
    .rate(s_r.sel.rate),
    .sample_tick(sample_tick)
  );

  // Pin view and channel geometry
  always_comb begin
    pins.rate = {rate_sel_hi, rate_sel_lo}; // RULE8
    pins.mem = {mem_count_sel_hi, mem_count_sel_lo}; // RULE11
    pins.phrase = {phrase_count_sel_hi, phrase_count_sel_lo}; // RULE12
    pins.ch = {channel_sel_2, channel_sel_1, channel_sel_0};
    share = vrc_pkg::share_calc(pins.mem, pins.phrase); // RULE13
    ch_eff = vrc_pkg::eff_channel(pins.mem, pins.phrase, pins.ch); // RULE14
    ch_base = 21'(share * ch_eff);
    // Channel zero begins past the index area
    ch_first = (ch_eff == 3'h0) ? vrc_pkg::INDEX_NIBBLES : ch_base; // RULE15 RULE19
  end

  assign active = (s_r.st == vrc_pkg::ST_REC) || (s_r.st == vrc_pkg::ST_PLAY) ||
                  (s_r.st == vrc_pkg::ST_XFER);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr_take;
    logic rd_drive;
    logic btn_rise;
    logic go;
    logic stop;
    logic go_rec;
    logic go_xfer;
    logic at_end;
    logic do_w;
    wr_take = 1'b0;
    rd_drive = 1'b0;
    btn_rise = 1'b0;
    go = 1'b0;
    stop = 1'b0;
    go_rec = 1'b0;
    go_xfer = 1'b0;
    at_end = 1'b0;
    do_w = 1'b0;
    s_nxt = s_r;
    s_nxt.mem_we = 1'b0;
    s_nxt.wr_prev = wr_n;
    s_nxt.btn_prev = btn_level;

    // Strobes count only while the chip is enabled
    wr_take = s_r.wr_prev && !wr_n && !chip_enable_inhibit; // RULE1 RULE3
    rd_drive = !rd_n && !chip_enable_inhibit; // RULE1 RULE3
    // Button acts only in stand-alone mode
    btn_rise = !s_r.mcu_mode && btn_level && !s_r.btn_prev; // RULE5 RULE18

    // Register bus: address and data accepted in either order
    s_nxt.rsp.awready = 1'b0;
    s_nxt.rsp.wready = 1'b0;
    s_nxt.rsp.arready = 1'b0;
    if (axi_req.awvalid && !s_r.aw_have && !s_r.rsp.awready && !s_r.rsp.bvalid) begin
      s_nxt.rsp.awready = 1'b1;
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_r.w_have && !s_r.rsp.wready && !s_r.rsp.bvalid) begin
      s_nxt.rsp.wready = 1'b1;
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = axi_req.wdata;
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid) begin
      do_w = 1'b1;
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = vrc_pkg::RESP_OKAY;
      if (s_r.aw_addr == vrc_pkg::REG_CTRL) begin
        s_nxt.mcu_mode = s_r.w_data[vrc_pkg::CTRL_MCU_BIT];
        s_nxt.sw_rec = s_r.w_data[vrc_pkg::CTRL_REC_BIT];
      end else if (s_r.aw_addr != vrc_pkg::REG_STATUS && s_r.aw_addr != vrc_pkg::REG_ADDR &&
                   s_r.aw_addr != vrc_pkg::REG_LIMIT) begin
        s_nxt.rsp.bresp = vrc_pkg::RESP_SLVERR;
      end
    end
    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_r.rsp.rvalid && !s_r.rsp.arready) begin
      s_nxt.rsp.arready = 1'b1;
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = vrc_pkg::RESP_OKAY;
      if (axi_req.araddr == vrc_pkg::REG_CTRL) begin
        s_nxt.rsp.rdata = {28'h0, s_r.sw_rec, s_r.mcu_mode, 2'h0};
      end else if (axi_req.araddr == vrc_pkg::REG_STATUS) begin
        s_nxt.rsp.rdata = {24'h0, s_r.sel.ch, 1'b0, s_r.st == vrc_pkg::ST_PD,
                           s_r.st == vrc_pkg::ST_XFER, s_r.mode_rec, active};
      end else if (axi_req.araddr == vrc_pkg::REG_ADDR) begin
        s_nxt.rsp.rdata = {11'h0, s_r.addr};
      end else if (axi_req.araddr == vrc_pkg::REG_LIMIT) begin
        s_nxt.rsp.rdata = {11'h0, s_r.limit};
      end else begin
        s_nxt.rsp.rdata = 32'h0;
        s_nxt.rsp.rresp = vrc_pkg::RESP_SLVERR;
      end
    end

    // Software start and stop join the button
    if (do_w && s_r.aw_addr == vrc_pkg::REG_CTRL) begin
      go = s_r.w_data[vrc_pkg::CTRL_START_BIT];
      stop = s_r.w_data[vrc_pkg::CTRL_STOP_BIT];
      go_rec = s_r.w_data[vrc_pkg::CTRL_REC_BIT];
    end
    if (btn_rise) begin
      go = !active;
      stop = active;
      go_rec = rec_play_sel;
    end

    // Nibble commands, or data nibbles during a transfer into memory
    if (wr_take) begin
      if (s_r.st == vrc_pkg::ST_XFER && !s_r.xfer_rec) begin
        s_nxt.data_wr = bus_in; // RULE3
        s_nxt.mem_we = 1'b1;
        if (bus_in == vrc_pkg::CMD_STOP) begin
          stop = 1'b1;
        end
      end else begin
        case (bus_in)
          vrc_pkg::CMD_PLAY: s_nxt.mode_rec = 1'b0;
          vrc_pkg::CMD_REC: s_nxt.mode_rec = 1'b1;
          vrc_pkg::CMD_START: begin
            go = 1'b1;
            go_rec = s_r.mode_rec;
          end
          vrc_pkg::CMD_STOP: stop = 1'b1;
          vrc_pkg::CMD_MEMORY_READ_CMD, vrc_pkg::CMD_EXTERNAL_RECORD_CMD: begin
            go_xfer = 1'b1;
            go_rec = 1'b1;
          end
          vrc_pkg::CMD_MEMORY_WRITE_CMD, vrc_pkg::CMD_EXTERNAL_PLAYBACK_CMD: begin
            go_xfer = 1'b1;
            go_rec = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end

    // Read strobe: data while transferring out, status otherwise
    s_nxt.bus_oe_n = !rd_drive; // RULE1
    if (rd_drive) begin
      if (s_r.st == vrc_pkg::ST_XFER && s_r.xfer_rec) begin
        s_nxt.bus_out = mem_nibble_in; // RULE3
      end else begin
        s_nxt.bus_out = {active, s_r.mode_rec, s_r.st == vrc_pkg::ST_XFER, 1'b0}; // RULE3
      end
    end

    at_end = (s_r.addr >= s_r.limit - 21'h000001);

    // Operation sequencing
    case (s_r.st)
      vrc_pkg::ST_PD, vrc_pkg::ST_IDLE: begin
        if (go || go_xfer) begin
          // Geometry and rate held for the whole operation
          s_nxt.sel = pins; // RULE20 RULE10
          s_nxt.addr = ch_first; // RULE19
          s_nxt.limit = ch_base + share; // RULE13
          s_nxt.mode_rec = go_rec;
          s_nxt.xfer_rec = go_rec;
          if (go_xfer) begin
            s_nxt.st = vrc_pkg::ST_XFER;
          end else begin
            s_nxt.st = go_rec ? vrc_pkg::ST_REC : vrc_pkg::ST_PLAY;
          end
        end else if (s_r.mcu_mode ? power_down_in : 1'b1) begin
          s_nxt.st = vrc_pkg::ST_PD; // RULE2 RULE7
        end else begin
          s_nxt.st = vrc_pkg::ST_IDLE;
        end
      end
      vrc_pkg::ST_REC, vrc_pkg::ST_PLAY, vrc_pkg::ST_XFER: begin
        if (stop) begin
          s_nxt.st = vrc_pkg::ST_IDLE;
        end else if (sample_tick) begin
          s_nxt.mem_we = s_r.st == vrc_pkg::ST_REC;
          if (s_r.st == vrc_pkg::ST_XFER) begin
            s_nxt.xclk = !s_r.xclk; // RULE4
          end
          if (at_end) begin
            if (s_r.st == vrc_pkg::ST_PLAY && btn_level && !s_r.mcu_mode) begin
              // Button still held: repeat the phrase
              s_nxt.addr = (s_r.sel.ch == 3'h0 || s_r.limit == vrc_pkg::share_calc(
                s_r.sel.mem, s_r.sel.phrase)) ? vrc_pkg::INDEX_NIBBLES :
                s_r.limit - vrc_pkg::share_calc(s_r.sel.mem, s_r.sel.phrase);
            end else begin
              s_nxt.st = vrc_pkg::ST_IDLE; // RULE16
            end
          end else begin
            s_nxt.addr = s_r.addr + 21'h000001; // RULE6
          end
        end
      end
      default: s_nxt.st = vrc_pkg::ST_IDLE;
    endcase

    if (s_nxt.st != vrc_pkg::ST_XFER) begin
      s_nxt.xclk = 1'b0;
    end
    s_nxt.mon_n = !(s_nxt.st == vrc_pkg::ST_REC || s_nxt.st == vrc_pkg::ST_PLAY); // RULE17
    s_nxt.osc_run = s_nxt.st != vrc_pkg::ST_PD; // RULE7 RULE9
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= vrc_pkg::ST_PD;
      s_r.wr_prev <= 1'b1;
      s_r.bus_oe_n <= 1'b1;
      s_r.mon_n <= 1'b1;
      s_r.mcu_mode <= vrc_pkg::CTRL_RST[0];
      s_r.sw_rec <= vrc_pkg::CTRL_RST[1];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp = s_r.rsp;
  assign bus_out = s_r.bus_out;
  assign bus_oe_n = s_r.bus_oe_n;
  assign transfer_sync_clock = s_r.xclk;
  assign mem_nibble_out = s_r.data_wr;
  assign mem_addr = s_r.addr;
  assign mem_write_en = s_r.mem_we;
  assign activity_monitor_n = s_r.mon_n;
  assign osc_run = s_r.osc_run;

endmodule // vrc_top

// ---- tb/vrc_properties.sv ----
module vrc_props_chk #(
  parameter int unsigned OSC_DIV = vrc_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched pins
  input wire logic rd_n,
  input wire logic chip_enable_inhibit,
  input wire logic bus_oe_n,
  input wire logic transfer_sync_clock,
  input wire logic rec_play_sel,
  input wire logic [20:0] mem_addr,
  input wire logic mem_write_en,
  input wire logic activity_monitor_n,
  input wire logic osc_run
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  localparam int unsigned LIM = 512 * OSC_DIV;
  int unsigned gap_r;
  // Cycles since address moved
  always_ff @(posedge clk) begin
    if (rst || activity_monitor_n || mem_addr != $past(mem_addr)) begin
      gap_r <= 0;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
  a_inhibit_release: assert property (chip_enable_inhibit && $past(chip_enable_inhibit) |-> bus_oe_n)
    else $error("bus driven while inhibited");
  a_read_cause: assert property (!bus_oe_n |-> !$past(rd_n) && !$past(chip_enable_inhibit))
    else $error("bus driven unread");
  a_busy_osc: assert property (!activity_monitor_n |-> osc_run)
    else $error("busy, oscillator off");
  a_sync_running: assert property ($changed(transfer_sync_clock) |-> $past(osc_run))
    else $error("sync clock in power-down");
  a_sync_quiet: assert property (!activity_monitor_n |-> !transfer_sync_clock)
    else $error("sync clock while busy");
  a_addr_step: assert property (!activity_monitor_n && $past(!activity_monitor_n) && rec_play_sel
      && $past(rec_play_sel) && mem_addr != $past(mem_addr) |-> mem_addr == $past(mem_addr) + 21'h1)
    else $error("address skipped a sample");
  a_write_pulse: assert property (mem_write_en |=> !mem_write_en)
    else $error("long write pulse");
  a_rate_bound: assert property (!activity_monitor_n |-> gap_r <= LIM)
    else $error("sample period too long");
  // Main scenarios reached
  c_read: cover property (!rd_n ##1 !bus_oe_n);
  c_sync: cover property ($rose(transfer_sync_clock));
  c_busy: cover property ($fell(activity_monitor_n));
endmodule // vrc_props_chk

bind vrc_top vrc_props_chk #(.OSC_DIV(OSC_DIV)) vrc_props_chk_i (.clk(clk), .rst(rst),
  .rd_n(rd_n), .chip_enable_inhibit(chip_enable_inhibit), .bus_oe_n(bus_oe_n),
  .transfer_sync_clock(transfer_sync_clock), .rec_play_sel(rec_play_sel), .mem_addr(mem_addr),
  .mem_write_en(mem_write_en), .activity_monitor_n(activity_monitor_n), .osc_run(osc_run));

// ---- tb/vrc_voice_mem.sv ----
module vrc_voice_mem (
  // Clock
  input wire logic clk,
  // Address and write side
  input wire logic [20:0] mem_addr,
  input wire logic mem_write_en,
  input wire logic [3:0] mem_nibble_out,
  // Read data
  output logic [3:0] mem_nibble_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Storage
  // ------
  // 256 aliased cells suffice here
  logic [3:0] cells [256];
  initial begin
    for (int i = 0; i < 256; i++) cells[i] = 4'(i);
  end
  // Write port
  always @(posedge clk) begin
    if (mem_write_en) cells[mem_addr[7:0]] <= mem_nibble_out;
  end
  assign mem_nibble_in = cells[mem_addr[7:0]];
endmodule // vrc_voice_mem

// ---- tb/vrc_tb_top.sv ----
module vrc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Wiring
  // ------
  logic clk = 1'b0;
  logic rst = 1'b1;
  vrc_pkg::vrc_axi_req_t req = '0;
  vrc_pkg::vrc_axi_rsp_t rsp;
  logic wr_n = 1'b1, rd_n = 1'b1;
  logic cei = 1'b0, pd = 1'b0, drv = 1'b0;
  logic [3:0] nib = 4'h0;
  logic btn = 1'b0; // Low outside presses
  logic rps = 1'b1;
  logic [1:0] rate = 2'h0, mem = 2'h0, ph = 2'h0;
  logic [2:0] ch = 3'h0;
  logic [3:0] bout, mni, mno;
  logic oe_n, tsc, amon_n, osc, wen;
  logic [20:0] addr;
  logic [1:0] r;
  logic [31:0] d;
  // Shared nibble bus
  wire [3:0] bus_w = drv ? nib : (!oe_n ? bout : ~bout);
  int n_fail = 0, compares = 0;
  localparam logic [9:0] DIVS [4] = '{vrc_pkg::RATE_DIV_LL, vrc_pkg::RATE_DIV_LH,
    vrc_pkg::RATE_DIV_HL, vrc_pkg::RATE_DIV_HH};
  always #12.5 clk = ~clk;
  // Short timings keep the run brief
  vrc_top #(.DEB_CYC(4), .OSC_DIV(1)) vrc_top_i (.clk(clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .wr_n(wr_n), .rd_n(rd_n), .chip_enable_inhibit(cei), .power_down_in(pd),
    .bus_in(bus_w), .bus_out(bout), .bus_oe_n(oe_n), .transfer_sync_clock(tsc),
    .start_stop_button(btn), .rec_play_sel(rps), .rate_sel_lo(rate[0]), .rate_sel_hi(rate[1]),
    .mem_count_sel_lo(mem[0]), .mem_count_sel_hi(mem[1]), .phrase_count_sel_lo(ph[0]),
    .phrase_count_sel_hi(ph[1]), .channel_sel_0(ch[0]), .channel_sel_1(ch[1]),
    .channel_sel_2(ch[2]), .mem_nibble_in(mni), .mem_nibble_out(mno), .mem_addr(addr),
    .mem_write_en(wen), .activity_monitor_n(amon_n), .osc_run(osc));
  vrc_voice_mem vrc_voice_mem_i (.clk(clk), .mem_addr(addr), .mem_write_en(wen),
    .mem_nibble_out(mno), .mem_nibble_in(mni));
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("Compares %0d, fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic nibw(input logic [3:0] v);
    @(posedge clk);
    nib <= v;
    drv <= 1'b1;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    drv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Press until the monitor reacts
  task automatic btn_hold(input logic v);
    @(posedge clk);
    btn <= 1'b1;
    for (int i = 0; i < 200 && amon_n !== v; i++) @(posedge clk);
  endtask
  task automatic btn_drop();
    repeat (2) @(posedge clk);
    btn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Register bus refusals and one accepted control write
  task automatic t_axi();
    axr(8'h10);
    chk("rresp", vrc_pkg::RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    axw(8'h20, 32'h0);
    chk("bresp bad", vrc_pkg::RESP_SLVERR, r);
    axw(vrc_pkg::REG_CTRL, 32'h4);
    chk("bresp", vrc_pkg::RESP_OKAY, r);
  endtask
  // Inhibit, read, power-down
  task automatic t_bus();
    @(posedge clk);
    cei <= 1'b1;
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe inhibited", 32'h1, oe_n);
    cei <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe read", 32'h0, oe_n);
    chk("status", 32'h0, bout);
    rd_n <= 1'b1;
    pd <= 1'b1;
    repeat (3) @(posedge clk);
    chk("oe idle", 32'h1, oe_n);
    chk("osc pd", 32'h0, osc);
    pd <= 1'b0;
  endtask
  // Transfer commands run the sync clock
  task automatic t_xfer();
    logic [3:0] cmds [4] = '{vrc_pkg::CMD_EXTERNAL_RECORD_CMD, vrc_pkg::CMD_EXTERNAL_PLAYBACK_CMD, vrc_pkg::CMD_MEMORY_WRITE_CMD,
      vrc_pkg::CMD_MEMORY_READ_CMD};
    for (int k = 0; k < 4; k++) begin
      nibw(cmds[k]);
      for (int i = 0; i < 1200 && tsc !== 1'b1; i++) @(posedge clk);
      chk("sync runs", 32'h1, tsc);
      chk("mon xfer", 32'h1, amon_n);
      nibw(vrc_pkg::CMD_STOP);
      chk("sync stops", 32'h0, tsc);
    end
    axw(vrc_pkg::REG_CTRL, 32'h0);
  endtask
  // Latched rate sets the sample period
  task automatic t_rate();
    logic [20:0] a0;
    int n;
    @(posedge clk);
    btn <= 1'b1;
    @(posedge clk);
    btn <= 1'b0;
    repeat (20) @(posedge clk);
    chk("short press", 32'h1, amon_n);
    for (int k = 0; k < 4; k++) begin
      rate <= 2'(k);
      btn_hold(1'b0);
      chk("mon rec", 32'h0, amon_n);
      chk("start", 32'h800, 32'(addr));
      btn_drop();
      rate <= ~2'(k);
      a0 = addr;
      for (int i = 0; i < 1200 && addr === a0; i++) @(posedge clk);
      a0 = addr;
      n = 0;
      while (addr === a0 && n < 1200) begin
        @(posedge clk);
        n++;
      end
      chk("period", 32'(DIVS[k]), 32'(n));
      btn_hold(1'b1);
      btn_drop();
      chk("osc idle", 32'h0, osc);
    end
  endtask
  // Two memories, eight phrases, channel 5
  task automatic t_chan();
    mem <= 2'h1;
    ph <= 2'h3;
    ch <= 3'h5;
    btn_hold(1'b0);
    chk("ch base", 32'h50000, 32'(addr));
    btn_drop();
    btn_hold(1'b1);
    btn_drop();
  endtask
  // ------
  // Sequence and watchdog
  // ------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk("mon rst", 32'h1, amon_n);
    chk("osc rst", 32'h0, osc);
    t_axi();
    t_bus();
    t_xfer();
    t_rate();
    t_chan();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule // vrc_tb_top
